// *** fcs_pkg.sv ***
/*
 * package for the flash command and status controller: APB register map,
 * field positions, reset values, command codes, key window and state codes.
 * assumes a 100 MHz bus clock and 32-bit APB data, 8-bit registers except the 16-bit array address and the 2-bit control register.
 */
package fcs_pkg;
   // register byte addresses on APB
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_PROTECTION = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_COMMAND = 8'h0C;
   localparam logic [7:0] ADDR_DIVIDER = 8'h10;
   localparam logic [7:0] ADDR_ARRAY_ADDR = 8'h14;
   localparam logic [7:0] ADDR_ARRAY_DATA = 8'h18;
   localparam logic [7:0] ADDR_CONTROL = 8'h1C;
   // config fields
   localparam int CFG_KEY_WRITE_BIT = 5;
   // protection fields
   localparam int PROT_DISABLE_BIT = 0;
   localparam int PROT_SELECT_LSB = 1;
   // status fields
   localparam int ST_BUF_EMPTY = 7;
   localparam int ST_COMPLETE = 6;
   localparam int ST_PROT_VIOL = 5;
   localparam int ST_ACC_ERR = 4;
   localparam int ST_BLANK = 2;
   // divider fields
   localparam int DIV_LOADED_BIT = 7;
   // control fields
   localparam int CTRL_STOP_BIT = 0;
   localparam int CTRL_DEBUG_BIT = 1;
   // reset values
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'hC0;
   localparam logic [7:0] RST_COMMAND = 8'h00;
   localparam logic [6:0] RST_DIVIDER = 7'h00;
   localparam logic [1:0] RST_SECURITY = 2'h0;
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   // key window
   localparam logic [15:0] KEY_LOW = 16'hFFB0;
   localparam logic [15:0] KEY_HIGH = 16'hFFB7;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [15:0] PAGE_MASK = 16'hFE00;
   // command codes
   localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
   localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
   localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
   localparam logic [7:0] CMD_FULL_ERASE = 8'h41;
   // apb answer
   localparam logic [31:0] APB_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      FCS_IDLE, FCS_START, FCS_WAIT, FCS_SCAN
   } fcs_state_t;
endpackage

// *** fcs_ctrl.sv ***
/*
 * flash command and status controller: APB register slave, command
 * decoder with one-deep burst buffer, protection check and array drive.
 * assumes an external array that answers ARR_DONE_I per operation, and a
 * nonvolatile protection byte that is valid in the first cycle after RST_I falls.
 */
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fcs_ctrl (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // nonvolatile copy and security
   input wire logic [7:0] NV_PROTECTION_I,
   output logic [1:0] SECURITY_CODE_O,
   output logic KEY_WRITE_O,
   // flash array
   output logic ARR_START_O,
   output logic [2:0] ARR_OP_O,
   output logic [15:0] ARR_ADDR_O,
   output logic [7:0] ARR_DATA_O,
   input wire logic ARR_DONE_I,
   input wire logic [7:0] ARR_RDATA_I,
   output logic ARR_BUSY_O
);
   typedef struct packed {
      fcs_pkg::fcs_state_t state;
      logic load_prot;
      logic [7:0] config_r;
      logic [7:0] prot;
      logic buf_empty, complete, pviol, accerr, blank;
      logic [6:0] divider;
      logic div_loaded;
      logic [15:0] addr;
      logic [7:0] data;
      logic [7:0] cmd;
      logic seq_ok;
      logic [1:0] ctrl;
      logic [1:0] security;
      logic pend;
      logic [7:0] pend_cmd;
      logic [15:0] pend_addr;
      logic [7:0] pend_data;
      logic start;
      logic [2:0] op;
      logic [15:0] op_addr;
      logic [7:0] op_data;
      logic erased;
      logic [7:0] op_cmd;
      logic [31:0] rdata;
   } fcs_regs_t;

   fcs_regs_t r, next_r;
   logic wr, rd;
   logic [15:0] prot_bound;
   logic stop_rise;
   localparam int PROT_SELECT_LSB_W = fcs_pkg::PROT_SELECT_LSB;

   assign wr = PSEL_I && PENABLE_I && PWRITE_I;
   // read data is captured in the setup cycle so it stands in the access
   assign rd = PSEL_I && !PENABLE_I && !PWRITE_I;
   // region above bound is protected; bound scaled by 512-byte steps
   assign prot_bound = {r.prot[7:PROT_SELECT_LSB_W], 9'h1FF};

   function automatic logic is_protected(input logic [7:0] prot,
                                         input logic [15:0] bound,
                                         input logic [15:0] a,
                                         input logic [7:0] c);
      logic hit;
      hit = 1'b0;
      if (!prot[fcs_pkg::PROT_DISABLE_BIT]) begin
         if (c == fcs_pkg::CMD_FULL_ERASE) begin
            hit = 1'b1;
         end else if (c == fcs_pkg::CMD_PAGE_ERASE) begin
            hit = (a | ~fcs_pkg::PAGE_MASK) > bound;
         end else begin
            hit = a > bound;
         end
      end
      return hit;
   endfunction

   function automatic logic legal(input logic [7:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         fcs_pkg::CMD_BLANK_CHECK, fcs_pkg::CMD_BYTE_PROGRAM,
         fcs_pkg::CMD_BURST_PROGRAM: ok = 1'b1;
         fcs_pkg::CMD_PAGE_ERASE, fcs_pkg::CMD_FULL_ERASE:
            ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic [2:0] op_of(input logic [7:0] c);
      logic [2:0] o;
      o = 3'h0;
      case (c)
         fcs_pkg::CMD_BLANK_CHECK: o = 3'h1;
         fcs_pkg::CMD_BYTE_PROGRAM: o = 3'h2;
         fcs_pkg::CMD_BURST_PROGRAM: o = 3'h3;
         fcs_pkg::CMD_PAGE_ERASE: o = 3'h4;
         fcs_pkg::CMD_FULL_ERASE: o = 3'h5;
         default: o = 3'h0;
      endcase
      return o;
   endfunction

   logic prev_stop;
   assign stop_rise = r.ctrl[fcs_pkg::CTRL_STOP_BIT] && !prev_stop;

   always_comb begin
      logic launch, running, in_key;
      logic [7:0] wb;
      next_r = r;
      launch = 1'b0;
      wb = PWDATA_I[7:0];
      running = (r.state != fcs_pkg::FCS_IDLE) || r.pend;
      in_key = 1'b0;
      next_r.start = 1'b0;
      next_r.load_prot = 1'b0;
      // software sees reset copy until debug changes it
      if (r.load_prot) begin
         next_r.prot = NV_PROTECTION_I;
      end
      if (rd) begin
         case (PADDR_I)
            fcs_pkg::ADDR_CONFIG: next_r.rdata = {24'h0, r.config_r};
            fcs_pkg::ADDR_PROTECTION: next_r.rdata = {24'h0, r.prot};
            fcs_pkg::ADDR_STATUS: next_r.rdata = {24'h0, r.buf_empty,
               r.complete, r.pviol, r.accerr, 1'b0, r.blank, 2'b00};
            fcs_pkg::ADDR_COMMAND: next_r.rdata = {24'h0, r.cmd};
            fcs_pkg::ADDR_DIVIDER: next_r.rdata = {24'h0, r.div_loaded,
               r.divider};
            fcs_pkg::ADDR_ARRAY_ADDR: next_r.rdata = {16'h0, r.addr};
            fcs_pkg::ADDR_ARRAY_DATA: next_r.rdata = {24'h0, r.data};
            fcs_pkg::ADDR_CONTROL: next_r.rdata = {30'h0, r.ctrl};
            default: next_r.rdata = fcs_pkg::APB_ZERO;
         endcase
      end
      if (wr) begin
         case (PADDR_I)
            fcs_pkg::ADDR_CONFIG: next_r.config_r = wb;
            fcs_pkg::ADDR_PROTECTION: begin
               if (r.ctrl[fcs_pkg::CTRL_DEBUG_BIT]) begin
                  next_r.prot = wb;
               end
            end
            fcs_pkg::ADDR_STATUS: begin
               if (wb[fcs_pkg::ST_PROT_VIOL]) begin
                  next_r.pviol = 1'b0;
               end
               if (wb[fcs_pkg::ST_ACC_ERR]) begin
                  next_r.accerr = 1'b0;
               end
               if (wb[fcs_pkg::ST_BUF_EMPTY] && r.buf_empty) begin
                  launch = 1'b1;
               end
            end
            fcs_pkg::ADDR_COMMAND: begin
               next_r.cmd = wb;
               if (!r.seq_ok) begin
                  next_r.accerr = 1'b1;
               end
            end
            fcs_pkg::ADDR_DIVIDER: begin
               next_r.divider = wb[6:0];
               next_r.div_loaded = 1'b1;
            end
            fcs_pkg::ADDR_ARRAY_ADDR: begin
               next_r.addr = PWDATA_I[15:0];
               in_key = (PWDATA_I[15:0] >= fcs_pkg::KEY_LOW) &&
                        (PWDATA_I[15:0] <= fcs_pkg::KEY_HIGH);
               // key writes are handed to the security logic instead
               if (!(in_key && r.config_r[fcs_pkg::CFG_KEY_WRITE_BIT])) begin
                  next_r.seq_ok = 1'b1;
               end
            end
            fcs_pkg::ADDR_ARRAY_DATA: next_r.data = wb;
            fcs_pkg::ADDR_CONTROL: next_r.ctrl = wb[1:0];
            default: ;
         endcase
      end
      if (launch) begin
         next_r.seq_ok = 1'b0;
         if (!r.seq_ok || !legal(r.cmd) || !r.div_loaded ||
             (running && r.cmd != fcs_pkg::CMD_BURST_PROGRAM)) begin
            next_r.accerr = 1'b1;
         end else if (r.cmd != fcs_pkg::CMD_BLANK_CHECK &&
                      is_protected(r.prot, prot_bound, r.addr, r.cmd)) begin
            next_r.pviol = 1'b1;
         end else begin
            next_r.buf_empty = 1'b0;
            next_r.complete = 1'b0;
            next_r.blank = 1'b0;
            if (running) begin
               next_r.pend = 1'b1;
               next_r.pend_cmd = r.cmd;
               next_r.pend_addr = r.addr;
               next_r.pend_data = r.data;
            end else begin
               next_r.state = fcs_pkg::FCS_START;
               next_r.op_cmd = r.cmd;
               next_r.op_addr = r.addr;
               next_r.op_data = r.data;
            end
         end
      end
      if (stop_rise && running) begin
         next_r.accerr = 1'b1;
      end
      case (r.state)
         fcs_pkg::FCS_IDLE: ;
         fcs_pkg::FCS_START: begin
            next_r.start = 1'b1;
            next_r.op = op_of(r.op_cmd);
            next_r.erased = 1'b1;
            if (r.op_cmd != fcs_pkg::CMD_BURST_PROGRAM || !r.pend) begin
               next_r.buf_empty = !r.pend || next_r.buf_empty;
            end
            next_r.state = fcs_pkg::FCS_WAIT;
         end
         fcs_pkg::FCS_WAIT: begin
            // the array answers one cycle after the start pulse
            if (!r.start && r.op_cmd == fcs_pkg::CMD_BLANK_CHECK &&
                ARR_RDATA_I != fcs_pkg::ERASED_BYTE) begin
               next_r.erased = 1'b0;
            end
            if (ARR_DONE_I) begin
               next_r.state = fcs_pkg::FCS_SCAN;
            end
         end
         fcs_pkg::FCS_SCAN: begin
            if (r.op_cmd == fcs_pkg::CMD_BLANK_CHECK && r.erased) begin
               next_r.blank = 1'b1;
               next_r.security = fcs_pkg::SEC_UNSECURED;
            end
            if (r.pend) begin
               // buffered burst moves to the array; buffer frees up
               next_r.pend = 1'b0;
               next_r.op_cmd = r.pend_cmd;
               next_r.op_addr = r.pend_addr;
               next_r.op_data = r.pend_data;
               next_r.buf_empty = 1'b1;
               next_r.state = fcs_pkg::FCS_START;
            end else begin
               next_r.buf_empty = 1'b1;
               next_r.complete = 1'b1;
               next_r.state = fcs_pkg::FCS_IDLE;
            end
         end
         default: next_r.state = fcs_pkg::FCS_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         r <= '0;
         r.state <= fcs_pkg::FCS_IDLE;
         r.load_prot <= 1'b1;
         r.config_r <= fcs_pkg::RST_CONFIG;
         r.buf_empty <= fcs_pkg::RST_STATUS[fcs_pkg::ST_BUF_EMPTY];
         r.complete <= fcs_pkg::RST_STATUS[fcs_pkg::ST_COMPLETE];
         r.cmd <= fcs_pkg::RST_COMMAND;
         r.divider <= fcs_pkg::RST_DIVIDER;
         r.security <= fcs_pkg::RST_SECURITY;
         prev_stop <= 1'b0;
      end else begin
         r <= next_r;
         prev_stop <= r.ctrl[fcs_pkg::CTRL_STOP_BIT];
      end
   end

   assign PRDATA_O = r.rdata;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = 1'b0;
   assign SECURITY_CODE_O = r.security;
   assign KEY_WRITE_O = r.config_r[fcs_pkg::CFG_KEY_WRITE_BIT];
   assign ARR_START_O = r.start;
   assign ARR_OP_O = r.op;
   assign ARR_ADDR_O = r.op_addr;
   assign ARR_DATA_O = r.op_data;
   assign ARR_BUSY_O = !r.complete;
endmodule
`default_nettype wire

// *** fcs_ctrl_props.sv ***
/* checker for fcs_ctrl: array drive, security code and status timing.
   assumes it is bound to fcs_ctrl and sees only that module's ports. */
`timescale 1ns/100ps
`default_nettype none
module fcs_ctrl_props (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   // security and array
   input wire logic [1:0] SECURITY_CODE_O,
   input wire logic KEY_WRITE_O,
   input wire logic ARR_START_O,
   input wire logic [2:0] ARR_OP_O,
   input wire logic ARR_DONE_I,
   input wire logic ARR_BUSY_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   logic acc;
   assign acc = PSEL_I && PENABLE_I;
   AST_KEY_BIT: assert property (acc && PWRITE_I &&
      PADDR_I == fcs_pkg::ADDR_CONFIG |=> KEY_WRITE_O == $past(PWDATA_I[5]))
      else $error("key write bit not taken");
   AST_START_PULSE: assert property (
      ARR_START_O |=> !ARR_START_O) else $error("start longer than one cycle");
   AST_OP_LEGAL: assert property (
      ARR_START_O |-> ARR_OP_O inside {[3'd1:3'd5]})
      else $error("array started with unknown op");
   AST_LAUNCH: assert property (
      $rose(ARR_BUSY_O) |-> ##[0:2] ARR_START_O)
      else $error("launch did not start the array");
   AST_BUSY_END: assert property (
      $fell(ARR_BUSY_O) |-> $past(ARR_DONE_I) || $past(ARR_DONE_I, 2))
      else $error("complete set before the array finished");
   AST_SEC_VALUE: assert property (
      !$stable(SECURITY_CODE_O) |-> SECURITY_CODE_O == fcs_pkg::SEC_UNSECURED)
      else $error("security code moved to a wrong value");
   AST_SEC_CAUSE: assert property (
      $changed(SECURITY_CODE_O) |-> $past(ARR_DONE_I) || $past(ARR_DONE_I, 2))
      else $error("security code changed with no finished check");
   AST_COMPLETE_READ: assert property (acc && !PWRITE_I &&
      PADDR_I == fcs_pkg::ADDR_STATUS |-> PRDATA_O[6] == !$past(ARR_BUSY_O))
      else $error("complete flag disagrees with busy");
   cover property (ARR_START_O && ARR_OP_O == 3'd3);
   cover property ($changed(SECURITY_CODE_O));
   cover property ($rose(KEY_WRITE_O));
endmodule
`default_nettype wire

// *** fcs_array_model.sv ***
/* flash array model: answers each start with one done pulse after LAT
   cycles, and reads erased bytes while busy.
   assumes a start pulse only while idle. */
`timescale 1ns/100ps
`default_nettype none
module fcs_array_model #(parameter int LAT = 30) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // array request
   input wire logic start_i,
   input wire logic [2:0] op_i,
   // array answer
   output logic done_o,
   output logic [7:0] rdata_o
);
   int cnt = 0;
   int starts = 0;
   logic [2:0] last_op = 3'h0;
   initial done_o = 1'b0;
   initial rdata_o = 8'h00;
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      // outside a scan the bus toggles so a stale erased byte is not seen
      rdata_o <= (cnt != 0 || start_i) ? 8'hFF : ~rdata_o;
      if (rst_i) begin
         cnt <= 0;
         starts <= 0;
      end else if (start_i) begin
         cnt <= LAT;
         starts <= starts + 1;
         last_op <= op_i;
      end else if (cnt == 1) begin
         cnt <= 0;
         done_o <= 1'b1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
/* testbench for fcs_ctrl: apb register tasks and command sequences.
   assumes fcs_pkg, fcs_ctrl, fcs_array_model and fcs_ctrl_props. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [7:0] A_CFG = fcs_pkg::ADDR_CONFIG;
   localparam logic [7:0] A_PROT = fcs_pkg::ADDR_PROTECTION;
   localparam logic [7:0] A_ST = fcs_pkg::ADDR_STATUS;
   localparam logic [7:0] A_DIV = fcs_pkg::ADDR_DIVIDER;
   localparam logic [7:0] A_CTL = fcs_pkg::ADDR_CONTROL;
   localparam logic [7:0] ERR = 8'h01 << fcs_pkg::ST_ACC_ERR;
   localparam logic [7:0] VIOL = 8'h01 << fcs_pkg::ST_PROT_VIOL;
   logic clk, rst, psel, pen, pwr, pready, start, done, busy, keyw;
   logic [7:0] paddr, nv, ardata;
   logic [31:0] pwdata, prdata;
   logic [15:0] rd;
   logic [2:0] op;
   logic [1:0] sec;
   logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
   int miscompares = 0;
   int compares = 0;
   int n0;
   fcs_ctrl i_dut (
      .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
      .NV_PROTECTION_I(nv), .SECURITY_CODE_O(sec), .KEY_WRITE_O(keyw),
      .ARR_START_O(start), .ARR_OP_O(op), .ARR_ADDR_O(), .ARR_DATA_O(),
      .ARR_DONE_I(done), .ARR_RDATA_I(ardata), .ARR_BUSY_O(busy)
   );
   fcs_array_model #(.LAT(30)) i_arr (
      .clk_i(clk), .rst_i(rst), .start_i(start), .op_i(op),
      .done_o(done), .rdata_o(ardata)
   );
   task automatic chk(input string n, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // read data is taken at the edge that completes the access
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata[15:0];
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, m, e);
      xfer(1'b0, a, 16'h0000);
      chk(n, {8'h00, rd[7:0] & m}, {8'h00, e});
   endtask
   task automatic cmd(input logic [15:0] a, input logic [7:0] c);
      xfer(1'b1, fcs_pkg::ADDR_ARRAY_ADDR, a);
      xfer(1'b1, fcs_pkg::ADDR_ARRAY_DATA, 16'h005A);
      xfer(1'b1, fcs_pkg::ADDR_COMMAND, {8'h00, c});
      xfer(1'b1, A_ST, 16'h0080);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk("idle wait", 16'(n < 200), 16'h0001);
   endtask
   task automatic do_reset(input logic [7:0] p, input int n);
      nv <= p;
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      nv = 8'h01;
      do_reset(8'h01, 12);
      rdchk("status", A_ST, 8'hFF, 8'hC0);
      xfer(1'b1, A_PROT, 16'h00FE);
      rdchk("protection", A_PROT, 8'hFF, 8'h01);
      xfer(1'b1, A_CFG, 16'h0020);
      chk("key write", {15'h0000, keyw}, 16'h0001);
      xfer(1'b1, A_CFG, 16'h0000);
      chk("key write", {15'h0000, keyw}, 16'h0000);
      // divider still unwritten: the command must be refused
      cmd(16'h0100, 8'h20);
      rdchk("error", A_ST, ERR, ERR);
      chk("starts", 16'(i_arr.starts), 16'h0000);
      rdchk("loaded", A_DIV, 8'h80, 8'h00);
      xfer(1'b1, A_ST, 16'h0000);
      rdchk("error", A_ST, ERR, ERR);
      xfer(1'b1, A_ST, {8'h00, ERR});
      rdchk("error", A_ST, ERR, 8'h00);
      xfer(1'b1, A_DIV, 16'h0013);
      rdchk("loaded", A_DIV, 8'h80, 8'h80);
      // full erase runs last and needs no blank check after it
      for (int i = 0; i < 5; i++) begin
         cmd(16'h0100, codes[i]);
         wait_idle();
         chk("op", {13'h0000, i_arr.last_op}, 16'(i + 1));
         rdchk("status", A_ST, 8'hF4, (i == 0) ? 8'hC4 : 8'hC0);
         if (i == 0)
            chk("security", {14'h0000, sec}, 16'h0002);
      end
      n0 = i_arr.starts;
      cmd(16'h0200, 8'h25);
      rdchk("buffer empty", A_ST, 8'h80, 8'h80);
      cmd(16'h0201, 8'h25);
      wait_idle();
      chk("bursts", 16'(i_arr.starts - n0), 16'h0002);
      rdchk("status", A_ST, 8'hF0, 8'hC0);
      cmd(16'h0100, 8'h33);
      rdchk("error", A_ST, ERR, ERR);
      xfer(1'b1, A_ST, {8'h00, ERR});
      cmd(16'h0100, 8'h20);
      xfer(1'b1, A_CTL, 16'h0001);
      rdchk("error", A_ST, ERR, ERR);
      xfer(1'b1, A_CTL, 16'h0000);
      wait_idle();
      xfer(1'b1, A_ST, {8'h00, ERR});
      // second reset: protected above 0x03FF
      do_reset(8'h02, 2);
      rdchk("protection", A_PROT, 8'hFF, 8'h02);
      chk("security", {14'h0000, sec}, 16'h0000);
      xfer(1'b1, A_DIV, 16'h0013);
      n0 = i_arr.starts;
      cmd(16'h0400, 8'h20);
      rdchk("violation", A_ST, VIOL | ERR, VIOL);
      chk("starts", 16'(i_arr.starts - n0), 16'h0000);
      xfer(1'b1, A_ST, {8'h00, VIOL});
      cmd(16'h03FF, 8'h20);
      wait_idle();
      rdchk("violation", A_ST, VIOL | ERR, 8'h00);
      xfer(1'b1, A_CTL, 16'h0002);
      xfer(1'b1, A_PROT, 16'h0003);
      xfer(1'b1, A_CTL, 16'h0000);
      rdchk("protection", A_PROT, 8'hFF, 8'h03);
      cmd(16'h0400, 8'h20);
      wait_idle();
      rdchk("violation", A_ST, VIOL | ERR, 8'h00);
      print_verdict();
   end
endmodule
bind fcs_ctrl fcs_ctrl_props i_props (
   .CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .SECURITY_CODE_O(SECURITY_CODE_O), .KEY_WRITE_O(KEY_WRITE_O),
   .ARR_START_O(ARR_START_O), .ARR_OP_O(ARR_OP_O),
   .ARR_DONE_I(ARR_DONE_I), .ARR_BUSY_O(ARR_BUSY_O)
);
`default_nettype wire
